// *** rtl/ttc_pkg.sv ***
// Purpose: Shared constants for the touch threshold compare block.
// Assumes: Byte-wide registers addressed by a 16-bit register address.
// Notes:   Offsets are byte addresses on the plain register port.
package ttc_pkg;

  // Geometry of the block.
  localparam int          TTC_NCH_MAX   = 6;
  localparam int          TTC_DW        = 8;
  localparam int          TTC_AW        = 16;
  localparam int          TTC_SW        = 16;
  localparam int          TTC_CHW       = 3;

  // Sample result byte offsets, indexed by channel.
  localparam logic [15:0] TTC_SMP_LO_OFS [TTC_NCH_MAX] =
    '{16'h00E1, 16'h00E3, 16'h00E5, 16'h00E7, 16'h00DA, 16'h00DC};
  localparam logic [15:0] TTC_SMP_HI_OFS [TTC_NCH_MAX] =
    '{16'h00E2, 16'h00E4, 16'h00E6, 16'h00D9, 16'h00DB, 16'h00DD};

  // Secondary threshold byte offsets, indexed by channel.
  localparam logic [15:0] TTC_SEC_LO_OFS [TTC_NCH_MAX] =
    '{16'h8050, 16'h8052, 16'h8054, 16'h8056, 16'h8058, 16'h805A};
  localparam logic [15:0] TTC_SEC_HI_OFS [TTC_NCH_MAX] =
    '{16'h8051, 16'h8053, 16'h8055, 16'h8057, 16'h8059, 16'h805B};

  // Flag, status and mask registers.
  localparam logic [15:0] TTC_FLAG_OFS  = 16'h00FB;
  localparam logic [15:0] TTC_PRIM_OFS  = 16'h805C;
  localparam logic [15:0] TTC_SECS_OFS  = 16'h805D;
  localparam logic [15:0] TTC_MASK_OFS  = 16'h8060;

  // Reset values.
  localparam logic [7:0]  TTC_BYTE_RST  = 8'h00;
  localparam logic [15:0] TTC_WORD_RST  = 16'h0000;

  // Direction encoding of a compare direction bit.
  localparam logic        TTC_DIR_BELOW = 1'b0;
  localparam logic        TTC_DIR_ABOVE = 1'b1;

endpackage

// *** rtl/ttc_thr_cmp.sv ***
// Purpose: One threshold comparison with a selectable direction.
// Assumes: Unsigned counts and thresholds of equal width.
// Notes:   Equality never counts as a crossing in either direction.
module ttc_thr_cmp
  import ttc_pkg::*;
#(
  parameter int W = TTC_SW
) (
  // Operands.
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] thresh,
  input  wire logic         dir,
  // Result.
  output logic              hit
);

  // Below when the direction is 0, above when it is 1.
  assign hit = (dir == TTC_DIR_ABOVE) ? (sample > thresh) : (sample < thresh);

endmodule

// *** rtl/ttc_threshold_compare.sv ***
// Purpose: Sample result store, threshold compare and event flags of the touch keys.
// Assumes: The front end delivers one sample per valid pulse, synchronous to mclk.
// Notes:   Primary thresholds and direction bits live elsewhere and arrive as inputs.
//          A crossing raises its event flag only when the status bit rises. A count
//          that stays across a threshold therefore interrupts once, not on every sample.
//          Status bits freeze while compare is off. Turning compare back on checks the
//          frozen state against the live result, which may raise a flag at once.
//          The mask register is local; software must open it to see any interrupt.
//
// Contract
// - With compare enabled every channel sample is checked against its secondary threshold.
// - Each secondary threshold is a read/write 16-bit value in a low and high byte, reset 0.
// - Each channel sample is readable as a low and high byte, read only, reset 0.
// - With compare enabled a crossing of either threshold sets the channel event flag.
// - Event flags sit in bits 5..0, bit 0 is channel 0, a written 1 clears, bits 7..6 unused.
// - Each channel keeps a primary crossing bit that shows whether the primary is crossed.
// - The primary compare direction bit of a channel sets the primary compare direction.
// - With compare enabled a primary crossing bit going to 1 sets the channel event flag.
// - A secondary crossing bit shows a secondary crossing and then sets the event flag.
// - The secondary compare direction bit of a channel sets the secondary compare direction.
// - Crossing status bits are set by hardware only and ignore software writes.
// - Direction 0 flags a count below the threshold, direction 1 a count above it.
// - With compare enabled each primary threshold is checked against its channel sample.
module ttc_threshold_compare
  import ttc_pkg::*;
#(
  parameter int NCH = TTC_NCH_MAX
) (
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Register port.
  input  wire logic [TTC_AW-1:0]    reg_addr,
  input  wire logic [TTC_DW-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [TTC_DW-1:0]    reg_rdata,
  // Sample delivery from the sensing front end.
  input  wire logic                 smp_valid,
  input  wire logic [TTC_CHW-1:0]   smp_chan,
  input  wire logic [TTC_SW-1:0]    smp_data,
  // Control from the surrounding touch registers.
  input  wire logic                 auto_compare_enable,
  input  wire logic [NCH*TTC_SW-1:0] primary_threshold,
  input  wire logic [NCH-1:0]       primary_compare_direction,
  input  wire logic [NCH-1:0]       secondary_compare_direction,
  // Interrupt.
  output logic                      irq
);

  // Refuse channel counts that the fixed register map cannot hold.
  if (NCH < 1 || NCH > TTC_NCH_MAX) begin : g_bad_nch
    $error("NCH must be between 1 and 6");
  end

  // Channels above NCH are absent; their offsets decode to nothing and read zero.

  // Storage.
  logic [TTC_SW-1:0] sample_r  [NCH];
  logic [TTC_SW-1:0] sec_thr_r [NCH];
  logic [NCH-1:0]    prim_cross_r;
  logic [NCH-1:0]    sec_cross_r;
  logic [NCH-1:0]    flags_r;
  logic [NCH-1:0]    flags_nxt;
  logic [NCH-1:0]    mask_r;
  logic [TTC_DW-1:0] rdata_r;

  // Decode of the shared registers.
  wire               flag_wr = reg_wr && (reg_addr == TTC_FLAG_OFS);
  wire               mask_wr = reg_wr && (reg_addr == TTC_MASK_OFS);
  wire [NCH-1:0]     flag_clr = flag_wr ? reg_wdata[NCH-1:0] : '0;

  // Per-channel decode, compare and event detection.
  logic [NCH-1:0]    smp_hit;
  logic [NCH-1:0]    sec_lo_wr;
  logic [NCH-1:0]    sec_hi_wr;
  logic [NCH-1:0]    prim_hit;
  logic [NCH-1:0]    sec_hit;
  logic [NCH-1:0]    prim_rise;
  logic [NCH-1:0]    sec_rise;
  logic [NCH-1:0]    evt_set;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign smp_hit[i]   = smp_valid && (smp_chan == TTC_CHW'(i));
    assign sec_lo_wr[i] = reg_wr && (reg_addr == TTC_SEC_LO_OFS[i]);
    assign sec_hi_wr[i] = reg_wr && (reg_addr == TTC_SEC_HI_OFS[i]);

    // Primary compare, direction chosen per channel.
    ttc_thr_cmp #(
      .W      (TTC_SW)
    ) u_prim (
      .sample (sample_r[i]),
      .thresh (primary_threshold[i*TTC_SW +: TTC_SW]),
      .dir    (primary_compare_direction[i]),
      .hit    (prim_hit[i])
    );

    // Secondary compare, direction chosen per channel.
    ttc_thr_cmp #(
      .W      (TTC_SW)
    ) u_sec (
      .sample (sample_r[i]),
      .thresh (sec_thr_r[i]),
      .dir    (secondary_compare_direction[i]),
      .hit    (sec_hit[i])
    );
  end

  // A new crossing only counts while compare is enabled.
  assign prim_rise = auto_compare_enable ? (prim_hit & ~prim_cross_r) : '0;
  assign sec_rise  = auto_compare_enable ? (sec_hit & ~sec_cross_r) : '0;
  assign evt_set   = prim_rise | sec_rise;

  // Set wins over a clear in the same cycle, so no crossing is lost.
  assign flags_nxt = (flags_r & ~flag_clr) | evt_set;

  // Interrupt is a level while any unmasked flag stands.
  assign irq = |(flags_r & mask_r);

  // Sample results are loaded only by the front end; writes never reach them.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) sample_r[i] <= TTC_WORD_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (smp_hit[i]) sample_r[i] <= smp_data;
      end
    end
  end

  // Secondary thresholds are written one byte at a time.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) sec_thr_r[i] <= TTC_WORD_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (sec_lo_wr[i]) sec_thr_r[i][7:0]  <= reg_wdata;
        if (sec_hi_wr[i]) sec_thr_r[i][15:8] <= reg_wdata;
      end
    end
  end

  // Crossing status follows the compare while enabled and holds otherwise.
  // Software has no path into these bits at all.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prim_cross_r <= '0;
      sec_cross_r  <= '0;
    end else if (auto_compare_enable) begin
      prim_cross_r <= prim_hit;
      sec_cross_r  <= sec_hit;
    end
  end

  // Event flags and their mask.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= '0;
      mask_r  <= '0;
    end else begin
      flags_r <= flags_nxt;
      if (mask_wr) mask_r <= reg_wdata[NCH-1:0];
    end
  end

  // Read selection; unmapped addresses and unused bits return zero.
  logic [TTC_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = TTC_BYTE_RST;
    for (int i = 0; i < NCH; i++) begin
      if (reg_addr == TTC_SMP_LO_OFS[i]) rd_mux = sample_r[i][7:0];
      if (reg_addr == TTC_SMP_HI_OFS[i]) rd_mux = sample_r[i][15:8];
      if (reg_addr == TTC_SEC_LO_OFS[i]) rd_mux = sec_thr_r[i][7:0];
      if (reg_addr == TTC_SEC_HI_OFS[i]) rd_mux = sec_thr_r[i][15:8];
    end
    if (reg_addr == TTC_FLAG_OFS) rd_mux = TTC_DW'(flags_r);
    if (reg_addr == TTC_PRIM_OFS) rd_mux = TTC_DW'(prim_cross_r);
    if (reg_addr == TTC_SECS_OFS) rd_mux = TTC_DW'(sec_cross_r);
    if (reg_addr == TTC_MASK_OFS) rd_mux = TTC_DW'(mask_r);
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= TTC_BYTE_RST;
    end else begin
      rdata_r <= reg_rd ? rd_mux : TTC_BYTE_RST;
    end
  end

  assign reg_rdata = rdata_r;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Mask fully opened while a flag stands and nothing clears it.
  sequence s_mask_open;
    mask_wr && (reg_wdata[NCH-1:0] == {NCH{1'b1}});
  endsequence
  sequence s_flag_pending;
    (|flags_r) && !flag_wr;
  endsequence

  a_rise_sets_flag: assert property ((|evt_set) |=> ((flags_r & $past(evt_set)) == $past(evt_set)))
    else $error("crossing did not set its event flag");
  a_w1c_clears: assert property ((flag_wr && (reg_wdata[0] == 1'b1) && !evt_set[0]) |=> !flags_r[0])
    else $error("writing one did not clear the event flag");
  a_set_beats_clr: assert property ((flag_wr && reg_wdata[0] && evt_set[0]) |=> flags_r[0])
    else $error("clear beat a simultaneous set");
  a_status_hold: assert property (!auto_compare_enable |=> ($stable(prim_cross_r) && $stable(sec_cross_r)))
    else $error("crossing status changed while compare was off");
  a_prim_above: assert property ((auto_compare_enable && primary_compare_direction[0] && (sample_r[0] > primary_threshold[TTC_SW-1:0])) |=> prim_cross_r[0])
    else $error("above crossing of the primary not seen");
  a_sec_below: assert property ((auto_compare_enable && !secondary_compare_direction[0] && (sample_r[0] < sec_thr_r[0])) |=> sec_cross_r[0])
    else $error("below crossing of the secondary not seen");
  a_no_flag_off: assert property ((!auto_compare_enable && !(|flags_r)) |=> !(|flags_r))
    else $error("event flag set while compare was off");
  a_sample_load: assert property ((smp_valid && (smp_chan == 3'h0)) |=> (sample_r[0] == $past(smp_data)))
    else $error("sample was not stored");
  a_thr_write: assert property (sec_lo_wr[0] |=> (sec_thr_r[0][7:0] == $past(reg_wdata)))
    else $error("secondary threshold low byte not written");
  a_flag_upper: assert property ((reg_rd && (reg_addr == TTC_FLAG_OFS)) |=> (reg_rdata[7:6] == 2'h0))
    else $error("unused flag bits read nonzero");
  a_read_idle: assert property (!reg_rd |=> (reg_rdata == TTC_BYTE_RST))
    else $error("read data outside the read answer cycle");
  a_irq_open: assert property ((s_mask_open and s_flag_pending) |=> irq)
    else $error("interrupt missing with mask open and flag set");

  // Status, flag and mask registers read back exactly what the hardware holds.
  a_read_prim: assert property ((reg_rd && (reg_addr == TTC_PRIM_OFS))
    |=> (reg_rdata == TTC_DW'($past(prim_cross_r))))
    else $error("primary status read back wrong");
  // The secondary status byte carries the secondary crossing bits.
  a_read_secs: assert property ((reg_rd && (reg_addr == TTC_SECS_OFS))
    |=> (reg_rdata == TTC_DW'($past(sec_cross_r))))
    else $error("secondary status read back wrong");
  // The flag byte carries the event flags.
  a_read_flags: assert property ((reg_rd && (reg_addr == TTC_FLAG_OFS))
    |=> (reg_rdata == TTC_DW'($past(flags_r))))
    else $error("event flags read back wrong");
  // The mask reads back as written.
  a_read_mask: assert property ((reg_rd && (reg_addr == TTC_MASK_OFS))
    |=> (reg_rdata == TTC_DW'($past(mask_r))))
    else $error("mask read back wrong");
  // Unused upper bits of the primary status stay zero.
  a_prim_upper: assert property ((reg_rd && (reg_addr == TTC_PRIM_OFS))
    |=> (reg_rdata[7:6] == 2'h0))
    else $error("unused primary status bits read nonzero");
  // Unused upper bits of the secondary status stay zero.
  a_secs_upper: assert property ((reg_rd && (reg_addr == TTC_SECS_OFS))
    |=> (reg_rdata[7:6] == 2'h0))
    else $error("unused secondary status bits read nonzero");
  // A mask write lands in the next cycle.
  a_mask_write: assert property (mask_wr
    |=> (mask_r == $past(reg_wdata[NCH-1:0])))
    else $error("mask write did not land");

  // Per-channel checks; guarding channel 0 alone would leave the rest unwatched.
  for (genvar k = 0; k < NCH; k++) begin : g_chk

    // A sample strobe for this channel, then a fresh primary crossing.
    sequence s_ch_load;
      smp_valid && (smp_chan == TTC_CHW'(k));
    endsequence
    sequence s_ch_prim_new;
      auto_compare_enable && prim_hit[k] && !prim_cross_r[k];
    endsequence

    // A written one with no event in the same cycle clears the flag.
    a_ch_w1c: assert property ((flag_clr[k] && !evt_set[k])
      |=> !flags_r[k])
      else $error("channel flag survived a written one");
    // An event always sets the flag, even against a clear.
    a_ch_set_wins: assert property (evt_set[k]
      |=> flags_r[k])
      else $error("channel event did not set its flag");
    // With neither event nor clear the flag holds.
    a_ch_flag_hold: assert property ((!flag_clr[k] && !evt_set[k])
      |=> (flags_r[k] == $past(flags_r[k])))
      else $error("channel flag changed on its own");

    // While enabled the primary status follows the live compare.
    a_ch_prim_track: assert property (auto_compare_enable
      |=> (prim_cross_r[k] == $past(prim_hit[k])))
      else $error("primary status did not follow the compare");
    // While enabled the secondary status follows the live compare.
    a_ch_sec_track: assert property (auto_compare_enable
      |=> (sec_cross_r[k] == $past(sec_hit[k])))
      else $error("secondary status did not follow the compare");
    // Direction 0 on the primary flags a count below the threshold.
    a_ch_prim_below: assert property ((auto_compare_enable
      && (primary_compare_direction[k] == TTC_DIR_BELOW)
      && (sample_r[k] < primary_threshold[k*TTC_SW +: TTC_SW])) |=> prim_cross_r[k])
      else $error("below crossing of the primary not seen");
    // Direction 1 on the secondary flags a count above the threshold.
    a_ch_sec_above: assert property ((auto_compare_enable
      && (secondary_compare_direction[k] == TTC_DIR_ABOVE)
      && (sample_r[k] > sec_thr_r[k])) |=> sec_cross_r[k])
      else $error("above crossing of the secondary not seen");
    // A count equal to the threshold is no crossing in either direction.
    a_ch_equal_quiet: assert property ((auto_compare_enable
      && (sample_r[k] == sec_thr_r[k])) |=> !sec_cross_r[k])
      else $error("equal count taken as a crossing");

    // A rising primary status raises the event flag.
    a_ch_prim_event: assert property (s_ch_prim_new
      |=> flags_r[k])
      else $error("primary crossing did not set the flag");
    // A rising secondary status raises the event flag.
    a_ch_sec_event: assert property ((auto_compare_enable && sec_hit[k] && !sec_cross_r[k])
      |=> flags_r[k])
      else $error("secondary crossing did not set the flag");
    // A fresh sample that newly crosses the primary ends in a raised flag.
    a_ch_load_flag: assert property ((s_ch_load ##1 s_ch_prim_new)
      |=> flags_r[k])
      else $error("new sample crossing did not set the flag");
    // With compare off no flag can rise.
    a_ch_flag_off: assert property ((!auto_compare_enable && !flags_r[k])
      |=> !flags_r[k])
      else $error("channel flag rose while compare was off");
    // With compare off the status bits freeze.
    a_ch_status_off: assert property (!auto_compare_enable
      |=> ($stable(prim_cross_r[k]) && $stable(sec_cross_r[k])))
      else $error("channel status moved while compare was off");

    // A strobe for this channel stores its count.
    a_ch_sample_load: assert property (s_ch_load
      |=> (sample_r[k] == $past(smp_data)))
      else $error("channel sample was not stored");
    // Without a strobe for this channel the count holds.
    a_ch_sample_keep: assert property (!(smp_valid && (smp_chan == TTC_CHW'(k)))
      |=> $stable(sample_r[k]))
      else $error("channel sample changed without a strobe");
    // The high threshold byte takes its write.
    a_ch_thr_hi: assert property (sec_hi_wr[k]
      |=> (sec_thr_r[k][15:8] == $past(reg_wdata)))
      else $error("secondary threshold high byte not written");
    // Without a write the threshold holds.
    a_ch_thr_keep: assert property ((!sec_lo_wr[k] && !sec_hi_wr[k])
      |=> $stable(sec_thr_r[k]))
      else $error("secondary threshold changed without a write");

    // The sample bytes read back as stored.
    a_ch_read_lo: assert property ((reg_rd && (reg_addr == TTC_SMP_LO_OFS[k]))
      |=> (reg_rdata == $past(sample_r[k][7:0])))
      else $error("sample low byte read back wrong");
    a_ch_read_hi: assert property ((reg_rd && (reg_addr == TTC_SMP_HI_OFS[k]))
      |=> (reg_rdata == $past(sample_r[k][15:8])))
      else $error("sample high byte read back wrong");
    // The threshold low byte reads back as written.
    a_ch_thr_rd: assert property ((reg_rd && (reg_addr == TTC_SEC_LO_OFS[k]))
      |=> (reg_rdata == $past(sec_thr_r[k][7:0])))
      else $error("threshold low byte read back wrong");
  end

endmodule

// *** verification/touch_threshold_compare_tb.sv ***
// Purpose: Self-checking bench for the touch threshold compare block.
// Assumes: Six channels; the bench models thresholds, samples and flags.
// Notes:   Reads queue their expectation; a monitor compares the next cycle.
module touch_threshold_compare_tb;
  import ttc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rstn, reg_wr, reg_rd, req, en, irq, smp_valid;
  logic        pend = 1'b0;
  logic [15:0] reg_addr, dat, smp_data, v;
  logic [7:0]  reg_wdata, reg_rdata, w;
  logic [2:0]  ch, smp_chan;
  logic [95:0] pth;
  logic [5:0]  pdir, sdir, pst, sst, flg;
  logic [15:0] smp [6];
  logic [15:0] sth [6];
  logic [7:0]  q [$];
  int          errors, n_checks, seed, c, n;
  ttc_fe_model ttc_fe_model_inst (.mclk(mclk), .rstn(rstn), .req(req), .ch(ch),
    .dat(dat), .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_data(smp_data));
  ttc_threshold_compare #(.NCH(6)) ttc_threshold_compare_inst (.mclk(mclk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
    .smp_chan(smp_chan), .smp_data(smp_data), .auto_compare_enable(en),
    .primary_threshold(pth), .primary_compare_direction(pdir),
    .secondary_compare_direction(sdir), .irq(irq));
  // Free-running 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (k) @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    q.push_back(e);
    @(posedge mclk);
  endtask
  function automatic logic hit(input logic [15:0] s, input logic [15:0] t, input logic d);
    return d ? (s > t) : (s < t);
  endfunction
  // While enabled, status follows the live compare; a rising status bit sets the flag.
  task automatic upd();
    logic np, ns;
    for (int i = 0; i < 6; i++) begin
      np = hit(smp[i], pth[16*i+:16], pdir[i]);
      ns = hit(smp[i], sth[i], sdir[i]);
      if (en) begin
        flg[i] = flg[i] | (np & ~pst[i]) | (ns & ~sst[i]);
        pst[i] = np;
        sst[i] = ns;
      end
    end
  endtask
  task automatic sample(input int k, input logic [15:0] d);
    idle(0);
    req <= 1'b1;
    ch  <= 3'(k);
    dat <= d;
    @(posedge mclk);
    req <= 1'b0;
    if (k < 6) smp[k] = d;
    upd();
    idle(4);
  endtask
  task automatic status(input int k);
    rd(TTC_PRIM_OFS, {2'b00, pst});
    rd(TTC_SECS_OFS, {2'b00, sst});
    rd(TTC_FLAG_OFS, {2'b00, flg});
    rd(TTC_SMP_LO_OFS[k], smp[k][7:0]);
    rd(TTC_SMP_HI_OFS[k], smp[k][15:8]);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Each read answer is compared with the oldest queued expectation.
  always @(posedge mclk) begin
    if (pend) chk(reg_rdata, q.pop_front());
    pend <= reg_rd;
  end
  // Watchdog against a hang.
  initial begin
    #2000000;
    errors++;
    results();
  end
  initial begin
    seed = 82;
    {rstn, req, en, reg_addr, reg_wdata, ch, dat} = '0;
    {pth, pdir, sdir, pst, sst, flg} = '0;
    for (int i = 0; i < 6; i++) {smp[i], sth[i]} = '0;
    idle(3);
    rstn <= 1'b1;
    idle(1);
    for (c = 0; c < 6; c++) begin
      status(c);
      rd(TTC_SEC_LO_OFS[c], TTC_BYTE_RST);
      rd(TTC_SEC_HI_OFS[c], TTC_BYTE_RST);
    end
    rd(TTC_MASK_OFS, TTC_BYTE_RST);
    $display("test reset values done");
    for (c = 0; c < 6; c++) begin
      sth[c] = 16'($random(seed));
      wr(TTC_SEC_LO_OFS[c], sth[c][7:0]);
      wr(TTC_SEC_HI_OFS[c], sth[c][15:8]);
      wr(TTC_SMP_LO_OFS[c], 8'hFF);
      rd(TTC_SEC_LO_OFS[c], sth[c][7:0]);
      rd(TTC_SEC_HI_OFS[c], sth[c][15:8]);
      rd(TTC_SMP_LO_OFS[c], TTC_BYTE_RST);
    end
    wr(TTC_PRIM_OFS, 8'hFF);
    wr(TTC_SECS_OFS, 8'hFF);
    rd(TTC_PRIM_OFS, 8'h00);
    rd(TTC_SECS_OFS, 8'h00);
    rd(16'h1234, 8'h00);
    $display("test register access done");
    en <= 1'b1;
    idle(1);
    upd();
    idle(3);
    for (n = 0; n < 24; n++) begin
      c = {$random(seed)} % 6;
      pdir <= 6'($random(seed));
      sdir <= 6'($random(seed));
      pth[16*c+:16] <= 16'($random(seed));
      idle(1);
      upd();
      v = 16'($random(seed));
      sth[c][7:0] = v[7:0];
      wr(TTC_SEC_LO_OFS[c], v[7:0]);
      upd();
      sth[c][15:8] = v[15:8];
      wr(TTC_SEC_HI_OFS[c], v[15:8]);
      upd();
      v = (n % 4 == 0) ? pth[16*c+:16] : 16'($random(seed));
      sample(c, v);
      status(c);
      w = 8'($random(seed));
      wr(TTC_MASK_OFS, w);
      idle(1);
      chk({7'h00, irq}, {7'h00, |(flg & w[5:0])});
      w = 8'($random(seed));
      wr(TTC_FLAG_OFS, w);
      flg = flg & ~w[5:0];
      idle(2);
      rd(TTC_FLAG_OFS, {2'b00, flg});
    end
    $display("test compare and flags done");
    sample(6, 16'($random(seed)));
    status(0);
    en <= 1'b0;
    idle(1);
    sample(1, 16'h0000);
    status(1);
    en <= 1'b1;
    idle(1);
    upd();
    idle(3);
    status(1);
    idle(2);
    $display("test enable gating done");
    results();
  end
endmodule

// *** verification/ttc_fe_model.sv ***
// Purpose: Behavioural sensing front end that delivers one count per request.
// Assumes: The bench raises req one cycle ahead of the strobe it wants.
// Notes:   Idle data and channel toggle, so a stale count is never taken as fresh.
module ttc_fe_model (
  // Clock, reset and bench request.
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        req,
  input  wire logic [2:0]  ch,
  input  wire logic [15:0] dat,
  // Sample strobe toward the block.
  output logic             smp_valid,
  output logic [2:0]       smp_chan,
  output logic [15:0]      smp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobe follows the request by one cycle; outside it the bus scrambles.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      smp_valid <= 1'b0;
      smp_chan  <= 3'h0;
      smp_data  <= 16'h0000;
    end else begin
      smp_valid <= req;
      smp_chan  <= req ? ch : ~smp_chan;
      smp_data  <= req ? dat : ~smp_data;
    end
  end
endmodule
